// ### ldds_map.svh
// Purpose: offsets, field positions, reset values and codes of the duty/status bank
// Assumes: included by bare name wherever a constant is needed
// Notes: definitions only
`ifndef LDDS_MAP_SVH
`define LDDS_MAP_SVH

// Serial address: upper five bits fixed, lower two from the strap pins
`define LDDS_ADDR_UPPER 5'h0e
// Register pointers
`define LDDS_OFS_CFG 8'h00
`define LDDS_OFS_DUTY 8'h04
`define LDDS_OFS_STAT 8'h05
// Reset values
`define LDDS_CFG_RST 16'h0000
`define LDDS_DUTY_RST 14'h0000
`define LDDS_OTP_CNT_RST 3'h0
// Identifier value is arbitrary
`define LDDS_DEVICE_ID 8'h5a
// Duty is honoured only in these two mode codes
`define LDDS_MODE_DUTY_A 3'h1
`define LDDS_MODE_DUTY_B 3'h5
// Over-temperature counter ceiling
`define LDDS_OTP_CNT_MAX 3'h5
// Status word fields
`define LDDS_STAT_ID_MSB 15
`define LDDS_STAT_ID_LSB 8
`define LDDS_STAT_CNT_MSB 7
`define LDDS_STAT_CNT_LSB 5
`define LDDS_STAT_OTP_BIT 4
`define LDDS_STAT_OCP_BIT 3
`define LDDS_STAT_OVP_BIT 2
`define LDDS_STAT_OPEN_BIT 1
`define LDDS_STAT_SHORT_BIT 0
`define LDDS_FLAG_COUNT 5
// Duty field width and serial bit slot of the acknowledge
`define LDDS_DUTY_W 14
`define LDDS_ACK_SLOT 4'h8
`define LDDS_LAST_BIT 4'h7
// Bit counter value between a start and its first clock fall
`define LDDS_PRE_BIT 4'hf

`endif

// ### ldds_pkg.sv
// Purpose: types of the duty/status bank
// Assumes: constants live in ldds_map.svh
// Notes: packed structs carry grouped signals and module state
package ldds_pkg;

    // Serial slave phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REG = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } ldds_bus_state_type;

    // Configuration word, msb first
    typedef struct packed {
        logic [7:0] full_scale_current_select;
        logic [1:0] over_voltage_threshold_select;
        logic [2:0] switching_frequency_select;
        logic [2:0] operating_mode_select;
    } ldds_cfg_type;

    // Fault events, ordered as the status flag bits 4..0
    typedef struct packed {
        logic over_temperature;
        logic over_current;
        logic over_voltage;
        logic string_open;
        logic string_short;
    } ldds_fault_type;

    // State of the bank apart from the latched fault flags
    typedef struct packed {
        ldds_bus_state_type bus_state;
        logic [3:0] bit_cnt;
        logic [7:0] rx_shift;
        logic [7:0] tx_shift;
        logic [7:0] hold;
        logic [7:0] ptr;
        logic read_dir;
        logic low_next;
        logic nack;
        logic drive;
        logic scl_q;
        logic sda_q;
        ldds_cfg_type cfg;
        logic [13:0] duty;
        logic [13:0] applied;
        logic [2:0] otp_cnt;
    } ldds_state_type;

    // State of one latched flag
    typedef struct packed {
        logic flag;
    } ldds_flag_state_type;

endpackage

// ### ldds_flag.sv
// Purpose: one latched fault flag, cleared by a status read
// Assumes: set and clear are one-cycle pulses on clk_in
// Notes: a set in the clearing cycle wins
`timescale 1ns/10ps
module ldds_flag (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Events
    input wire logic set_in,
    input wire logic clr_in,
    // Flag
    output logic flag_out
);
    ldds_pkg::ldds_flag_state_type r;
    ldds_pkg::ldds_flag_state_type next_r;

    // Set has priority so no fault is lost during a read
    always_comb begin
        next_r = r;
        if (set_in) begin
            next_r.flag = 1'b1;
        end else if (clr_in) begin
            next_r.flag = 1'b0;
        end
    end

    // Flags are clear out of reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign flag_out = r.flag;

    property p_set_wins;
        @(posedge clk_in) disable iff (!nrst_in) set_in |=> flag_out;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost a set");
endmodule

// ### ldds_top.sv
// Purpose: dimming duty and fault status registers behind a two-wire serial slave
// Assumes: scl/sda inputs already synchronous to clk_in; fault inputs are one-cycle pulses
// Notes: 16-bit words move high byte first; the status word is captured whole at the read
`timescale 1ns/10ps
`include "ldds_map.svh"
module ldds_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Serial bus, sda open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic [1:0] addr_sel_in,
    // Protection events
    input wire ldds_pkg::ldds_fault_type fault_in,
    // Settings to the power stage
    output logic [13:0] dimming_duty_out,
    output logic [2:0] operating_mode_select_out,
    output logic [2:0] switching_frequency_select_out,
    output logic [7:0] full_scale_current_select_out,
    output logic [1:0] over_voltage_threshold_select_out
);
    ldds_pkg::ldds_state_type r;
    ldds_pkg::ldds_state_type next_r;
    logic [4:0] flags;
    logic clr_flags;
    logic [15:0] rd_word;
    logic mode_ok;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // Bus conditions from the previous samples
    assign scl_rise = scl_in & ~r.scl_q;
    assign scl_fall = ~scl_in & r.scl_q;
    assign bus_start = r.scl_q & scl_in & r.sda_q & ~sda_in;
    assign bus_stop = r.scl_q & scl_in & ~r.sda_q & sda_in;
    assign mode_ok = (r.cfg.operating_mode_select == `LDDS_MODE_DUTY_A) ||
                     (r.cfg.operating_mode_select == `LDDS_MODE_DUTY_B);

    // One latch per fault, bit order follows the status word
    genvar gi;
    generate
        for (gi = 0; gi < `LDDS_FLAG_COUNT; gi++) begin : g_flag
            ldds_flag u_flag (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .set_in(fault_in[gi]),
                .clr_in(clr_flags),
                .flag_out(flags[gi])
            );
        end
    endgenerate

    // Read mux; unmapped pointers read zero
    always_comb begin
        if (r.ptr == `LDDS_OFS_CFG) begin
            rd_word = r.cfg;
        end else if (r.ptr == `LDDS_OFS_DUTY) begin
            rd_word = {2'b00, r.duty};
        end else if (r.ptr == `LDDS_OFS_STAT) begin
            rd_word = {`LDDS_DEVICE_ID, r.otp_cnt, flags};
        end else begin
            rd_word = 16'h0000;
        end
    end

    // Next state: counter, applied duty and serial slave
    always_comb begin
        next_r = r;
        clr_flags = 1'b0;
        next_r.scl_q = scl_in;
        next_r.sda_q = sda_in;
        // Saturates so a long fault history cannot wrap to zero
        if (fault_in.over_temperature && (r.otp_cnt != `LDDS_OTP_CNT_MAX)) begin
            next_r.otp_cnt = r.otp_cnt + 3'h1;
        end
        next_r.applied = mode_ok ? r.duty : `LDDS_DUTY_RST;
        if (bus_start) begin
            next_r.bus_state = ldds_pkg::ST_ADDR;
            // The start's own clock fall wraps this to zero, so it is not counted as a bit
            next_r.bit_cnt = `LDDS_PRE_BIT;
            next_r.drive = 1'b0;
        end else if (bus_stop) begin
            next_r.bus_state = ldds_pkg::ST_IDLE;
            next_r.drive = 1'b0;
        end else if (r.bus_state != ldds_pkg::ST_IDLE) begin
            if (scl_rise) begin
                if (r.bit_cnt < `LDDS_ACK_SLOT) begin
                    next_r.rx_shift = {r.rx_shift[6:0], sda_in};
                end else begin
                    next_r.nack = sda_in;
                end
            end
            if (scl_fall) begin
                if (r.bit_cnt == `LDDS_LAST_BIT) begin
                    // Byte done: acknowledge slot follows
                    next_r.bit_cnt = `LDDS_ACK_SLOT;
                    next_r.drive = 1'b1;
                    case (r.bus_state)
                        ldds_pkg::ST_ADDR: begin
                            if (r.rx_shift[7:1] != {`LDDS_ADDR_UPPER, addr_sel_in}) begin
                                next_r.bus_state = ldds_pkg::ST_IDLE;
                                next_r.drive = 1'b0;
                            end
                            next_r.read_dir = r.rx_shift[0];
                        end
                        ldds_pkg::ST_REG: begin
                            next_r.ptr = r.rx_shift;
                            next_r.low_next = 1'b0;
                        end
                        ldds_pkg::ST_WDATA: begin
                            next_r.low_next = ~r.low_next;
                            if (!r.low_next) begin
                                next_r.hold = r.rx_shift;
                            end else if (r.ptr == `LDDS_OFS_CFG) begin
                                next_r.cfg = {r.hold, r.rx_shift};
                            end else if (r.ptr == `LDDS_OFS_DUTY) begin
                                next_r.duty = {r.hold[5:0], r.rx_shift};
                            end
                        end
                        default: begin
                            next_r.drive = 1'b0; // Host acknowledges our byte
                        end
                    endcase
                end else if (r.bit_cnt == `LDDS_ACK_SLOT) begin
                    next_r.bit_cnt = 4'h0;
                    next_r.drive = 1'b0;
                    case (r.bus_state)
                        ldds_pkg::ST_ADDR: begin
                            next_r.bus_state = r.read_dir ? ldds_pkg::ST_RDATA : ldds_pkg::ST_REG;
                        end
                        ldds_pkg::ST_REG: begin
                            next_r.bus_state = ldds_pkg::ST_WDATA;
                        end
                        ldds_pkg::ST_RDATA: begin
                            if (r.nack) begin
                                next_r.bus_state = ldds_pkg::ST_IDLE;
                            end
                        end
                        default: begin
                            next_r.bus_state = r.bus_state;
                        end
                    endcase
                    // Load the next byte to send
                    if (next_r.bus_state == ldds_pkg::ST_RDATA) begin
                        if (!r.low_next || (r.bus_state == ldds_pkg::ST_ADDR)) begin
                            next_r.tx_shift = rd_word[15:8];
                            next_r.hold = rd_word[7:0];
                            next_r.low_next = 1'b1;
                            clr_flags = (r.ptr == `LDDS_OFS_STAT);
                        end else begin
                            next_r.tx_shift = r.hold;
                            next_r.low_next = 1'b0;
                        end
                        next_r.drive = ~next_r.tx_shift[7];
                    end
                end else begin
                    next_r.bit_cnt = r.bit_cnt + 4'h1;
                    if (r.bus_state == ldds_pkg::ST_RDATA) begin
                        next_r.tx_shift = {r.tx_shift[6:0], 1'b0};
                        next_r.drive = ~r.tx_shift[6];
                    end
                end
            end
        end
    end

    // Register the whole state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.cfg <= `LDDS_CFG_RST;
            r.duty <= `LDDS_DUTY_RST;
            r.otp_cnt <= `LDDS_OTP_CNT_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs from flops, except sda_out, which is tied low
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~r.drive;
    assign dimming_duty_out = r.applied;
    assign operating_mode_select_out = r.cfg.operating_mode_select;
    assign switching_frequency_select_out = r.cfg.switching_frequency_select;
    assign full_scale_current_select_out = r.cfg.full_scale_current_select;
    assign over_voltage_threshold_select_out = r.cfg.over_voltage_threshold_select;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_duty_on;
        mode_ok |=> (dimming_duty_out == $past(r.duty));
    endproperty
    a_duty_on: assert property (p_duty_on) else $error("duty not applied in duty mode");
    property p_duty_off;
        !mode_ok |=> (dimming_duty_out == 14'h0000);
    endproperty
    a_duty_off: assert property (p_duty_off) else $error("duty leaked in other mode");
    property p_cnt_inc;
        (fault_in.over_temperature && (r.otp_cnt < 3'h5)) |=> (r.otp_cnt == $past(r.otp_cnt) + 3'h1);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed an event");
    property p_cnt_sat;
        (r.otp_cnt == 3'h5) |=> (r.otp_cnt == 3'h5);
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter passed five");
    property p_cnt_quiet;
        !fault_in.over_temperature |=> $stable(r.otp_cnt);
    endproperty
    a_cnt_quiet: assert property (p_cnt_quiet) else $error("counter moved without event");
    property p_ocp_hold;
        (flags[3] && !clr_flags) |=> flags[3];
    endproperty
    a_ocp_hold: assert property (p_ocp_hold) else $error("flag dropped without read");
    property p_stat_map;
        (r.ptr == 8'h05) |-> (rd_word[4:0] == flags) && (rd_word[7:5] == r.otp_cnt);
    endproperty
    a_stat_map: assert property (p_stat_map) else $error("status layout wrong");
    property p_duty_rsvd;
        (r.ptr == 8'h04) |-> (rd_word[15:14] == 2'b00) && (rd_word[13:0] == r.duty);
    endproperty
    a_duty_rsvd: assert property (p_duty_rsvd) else $error("duty read wrong");
    property p_clr_flags;
        (clr_flags && !fault_in.string_short) |=> !flags[0];
    endproperty
    a_clr_flags: assert property (p_clr_flags) else $error("flag survived read");

    c_stat_read: cover property (clr_flags && (flags != 5'h00));
    c_duty_write: cover property ((r.duty != 14'h0000) && mode_ok);
    c_cnt_full: cover property (r.otp_cnt == 3'h5);
endmodule

// ### ldds_host.sv
// Purpose: two-wire serial host model that drives the duty/status bank
// Assumes: the bench resolves the open-drain data line with a pull-up
// Notes: bus edges four clocks apart, except one clock from a clock fall to the next data change
`timescale 1ns/10ps
module ldds_host (
    // Clock
    input wire logic clk_in,
    // Target address
    input wire logic [6:0] addr_in,
    // Serial bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    // Bus idles released and high
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Start, also usable as repeated start from a low clock phase
    task automatic start();
        sda_oe_n_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_n_out <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
        tick(1);
    endtask

    task automatic stop();
        sda_oe_n_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_n_out <= 1'b1;
        tick(4);
    endtask

    // One bit slot; a one releases the line so the slave may drive it
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n_out <= b;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        r = sda_in;
        scl_out <= 1'b0;
        tick(1);
    endtask

    // Eight data slots then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic hb, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(hb, r);
        ack = ~r;
    endtask

    task automatic write_word(input logic [7:0] ptr, input logic [15:0] w, output logic ok);
        logic [7:0] q;
        logic a;
        start();
        xfer({addr_in, 1'b0}, 1'b1, q, ok);
        xfer(ptr, 1'b1, q, a);
        xfer(w[15:8], 1'b1, q, a);
        xfer(w[7:0], 1'b1, q, a);
        stop();
    endtask

    // Pointer write, repeated start, then one word with a final not-acknowledge
    task automatic read_word(input logic [7:0] ptr, output logic [15:0] w, output logic ok);
        logic [7:0] q;
        logic a;
        start();
        xfer({addr_in, 1'b0}, 1'b1, q, ok);
        xfer(ptr, 1'b1, q, a);
        start();
        xfer({addr_in, 1'b1}, 1'b1, q, a);
        xfer(8'hff, 1'b0, w[15:8], a);
        xfer(8'hff, 1'b1, w[7:0], a);
        stop();
    endtask
endmodule

// ### tb_led_dimming_duty_and_fault_status.sv
// Purpose: self-checking bench for the duty/status bank over its serial bus
// Assumes: host model paces the bus; faults are one-clock pulses
// Notes: expectations come from field layout, not from design outputs
`timescale 1ns/10ps
`include "ldds_map.svh"
module tb_led_dimming_duty_and_fault_status;
    logic clk_in;
    logic nrst_in;
    logic [1:0] addr_sel_in;
    ldds_pkg::ldds_fault_type fault_in;
    logic [6:0] host_addr;
    logic scl;
    logic host_oe_n;
    logic dev_sda;
    logic dev_oe_n;
    logic sda_wire;
    logic [13:0] duty_out;
    logic [2:0] mode_out;
    logic [2:0] freq_out;
    logic [7:0] cur_out;
    logic [1:0] ovp_out;
    logic [15:0] w;
    logic [2:0] cnt;
    int n_tests;
    int n_mismatch;

    // Open drain with pull-up: low if either party pulls
    assign sda_wire = (dev_oe_n | dev_sda) & host_oe_n;

    ldds_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(dev_sda),
        .sda_oe_n_out(dev_oe_n), .addr_sel_in(addr_sel_in), .fault_in(fault_in),
        .dimming_duty_out(duty_out), .operating_mode_select_out(mode_out),
        .switching_frequency_select_out(freq_out), .full_scale_current_select_out(cur_out),
        .over_voltage_threshold_select_out(ovp_out));

    ldds_host host (.clk_in(clk_in), .addr_in(host_addr), .sda_in(sda_wire), .scl_out(scl),
        .sda_oe_n_out(host_oe_n));

    always #2.5 clk_in = ~clk_in;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register write; the acknowledge of the address is compared too
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic exp_ok);
        logic ok;
        host.write_word(p, d, ok);
        check({15'h0000, ok}, {15'h0000, exp_ok});
    endtask

    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        logic ok;
        host.read_word(p, d, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask

    // One-clock fault pulse on the chosen sources
    task automatic pulse(input logic [4:0] f);
        fault_in <= f;
        @(posedge clk_in);
        fault_in <= 5'h00;
        @(posedge clk_in);
    endtask

    task automatic conclude();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, several times the expected run length
    initial begin
        repeat (90000) @(posedge clk_in);
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        clk_in = 1'b0;
        nrst_in = 1'b0;
        addr_sel_in = 2'h2;
        fault_in = 5'h00;
        host_addr = {`LDDS_ADDR_UPPER, 2'h2};
        n_tests = 0;
        n_mismatch = 0;
        cnt = 3'h0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        // Reset values
        rd(`LDDS_OFS_DUTY, w);
        check(w, 16'h0000);
        rd(`LDDS_OFS_STAT, w);
        check(w, {`LDDS_DEVICE_ID, 8'h00});
        $display("test reset done");
        // Full scale duty; reserved bits stay clear; mode 0 does not apply it
        wr(`LDDS_OFS_DUTY, 16'hffff, 1'b1);
        rd(`LDDS_OFS_DUTY, w);
        check(w, 16'h3fff);
        check({2'h0, duty_out}, 16'h0000);
        // Every mode code, with the other configuration fields set
        for (int m = 0; m < 8; m++) begin
            wr(`LDDS_OFS_CFG, {8'hc3, 2'h2, 3'h6, 3'(m)}, 1'b1);
            repeat (2) @(posedge clk_in);
            check({2'h0, duty_out}, (m == 1 || m == 5) ? 16'h3fff : 16'h0000);
            check({cur_out, ovp_out, freq_out, mode_out}, {8'hc3, 2'h2, 3'h6, 3'(m)});
        end
        wr(`LDDS_OFS_CFG, 16'h0005, 1'b1);
        wr(`LDDS_OFS_DUTY, 16'hd001, 1'b1);
        repeat (2) @(posedge clk_in);
        check({2'h0, duty_out}, 16'h1001);
        $display("test duty done");
        // Each flag alone: latched, then gone after the read
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            if (i == 4) begin
                cnt = cnt + 3'h1;
            end
            rd(`LDDS_OFS_STAT, w);
            check(w, {`LDDS_DEVICE_ID, cnt, 5'h01 << i});
            rd(`LDDS_OFS_STAT, w);
            check(w, {`LDDS_DEVICE_ID, cnt, 5'h00});
        end
        // Counter stops at five; all sources together
        repeat (6) pulse(5'h10);
        pulse(5'h1f);
        rd(`LDDS_OFS_STAT, w);
        check(w, {`LDDS_DEVICE_ID, 3'h5, 5'h1f});
        $display("test flags done");
        // Foreign address is not acknowledged and changes nothing
        host_addr <= {`LDDS_ADDR_UPPER, 2'h1};
        wr(`LDDS_OFS_DUTY, 16'h0000, 1'b0);
        host_addr <= {`LDDS_ADDR_UPPER, 2'h2};
        wr(`LDDS_OFS_STAT, 16'h0000, 1'b1);
        rd(`LDDS_OFS_DUTY, w);
        check(w, 16'h1001);
        rd(`LDDS_OFS_STAT, w);
        check(w, {`LDDS_DEVICE_ID, 3'h5, 5'h00});
        rd(8'h07, w);
        check(w, 16'h0000);
        $display("test refusals done");
        conclude();
    end
endmodule
